// ---- verilog/fra_unit.sv ----
// Floating absolute/add datapath with APB register access
`timescale 1ns/1ns
`default_nettype none
// Functional notes
// RULE1: Zero exponent operand is exact zero
// RULE2: Zero operand gives exact result
// RULE3: Zero divisor traps, no quotient
// RULE4: Fractions normalised, 24 or 56 bits
// RULE5: Two guard bits kept in arithmetic
// RULE6: Chop within 1 LSB, round 1/2
// RULE7: Round adds LSB when rounding bit set
// RULE8: Exponent out of range flags over/underflow
// RULE9: Masked underflow stores exact zero silently
// RULE10: Enabled trap stores fraction, low exponent
// RULE11: Overflow exponent stored 400 octal smaller
// RULE12: Underflow exponent stored 400 octal larger
// RULE13: Overflow trap sets overflow flag, code
// RULE14: Double select picks operand precision
// RULE15: Long select picks 32 or 16-bit integers
// RULE16: Instruction field layout, major code 17
// RULE17: Float modes versus CPU modes for operands
// RULE18: Absolute: zero or magnitude, set flags
// RULE19: Absolute traps on -0, never overflows
// RULE20: Add writes sum, masked error stores zero
// RULE21: Chop select truncates, else rounds
// RULE22: Codes 8, 10, 12 and lower
// RULE23: Enables turn over/underflow into trap
// RULE24: Rounding carry renormalises before check
module fra_unit
    import fra_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic fp_trap,
    output logic float_double_sel,
    output logic long_integer_sel
);
    import fra_pkg::*;

    // Complete module state
    typedef struct packed {
        fra_state_t st;
        logic [15:0] stat;
        logic [3:0] ecode;
        logic [15:0] instr;
        logic [63:0] opnd;
        logic [63:0] res;
        logic [5:0][63:0] acc;
        logic [31:0] rdata;
        logic trap;
        logic trapped;
    } fra_regs_t;

    fra_regs_t state_reg;
    fra_regs_t state_next;

    // Bus phase decode
    logic setup;
    logic access;
    logic hit;
    logic [31:0] rd_val;
    logic [2:0] acc_idx;

    // Instruction fields
    logic [2:0] mode;
    logic [2:0] rn;
    logic [1:0] acn;
    logic dbl;
    logic [63:0] fmask;
    logic [63:0] ac_v;
    logic [63:0] src_v;
    logic src_neg0;

    // Adder datapath
    logic a_z;
    logic b_z;
    logic swap;
    logic [57:0] big_f;
    logic [57:0] sm_f;
    logic [57:0] al_f;
    logic [7:0] big_e;
    logic [7:0] sm_e;
    logic big_s;
    logic sm_s;
    logic [58:0] sum;
    logic [5:0] lz;
    logic [57:0] nf;
    logic [10:0] ne;
    logic [55:0] rf;
    logic [10:0] re;
    logic add_zero;
    logic add_ovf;
    logic add_unf;
    logic [63:0] add_val;

    // Leading zero count of a fraction
    function automatic logic [5:0] lzc(input logic [57:0] v);
        logic [5:0] n;
        logic found;
        n = '0;
        found = 1'b0;
        for (int i = 57; i >= 0; i--) begin
            if (!found && v[i]) begin
                n = 6'(57 - i);
                found = 1'b1;
            end
        end
        return n;
    endfunction

    // APB phases; slave is always ready
    assign setup = psel && !penable;
    assign access = psel && penable;
    assign pready = 1'b1;
    assign prdata = state_reg.rdata;
    assign fp_trap = state_reg.trap;
    assign float_double_sel = state_reg.stat[ST_DBL];
    assign long_integer_sel = state_reg.stat[ST_LONG]; // RULE15
    assign acc_idx = 3'((paddr - OFF_ACC) >> 3);

    // Address decode and read mux
    always_comb begin
        hit = 1'b1;
        rd_val = 32'h0000_0000;
        case (paddr)
            OFF_STAT: rd_val = {16'h0000, state_reg.stat};
            OFF_ECODE: rd_val = {28'h000_0000, state_reg.ecode};
            OFF_INSTR: rd_val = {16'h0000, state_reg.instr};
            OFF_OPHI: rd_val = state_reg.opnd[63:32];
            OFF_OPLO: rd_val = state_reg.opnd[31:0];
            OFF_RSHI: rd_val = state_reg.res[63:32];
            OFF_RSLO: rd_val = state_reg.res[31:0];
            OFF_EXST: begin
                rd_val = {30'h0000_0000, state_reg.trapped,
                    state_reg.st == FRA_EXEC};
            end
            default: begin
                // Accumulators: high word, then low word
                if (paddr >= OFF_ACC && paddr < OFF_ACC_END && paddr[1:0] == 2'b00) begin
                    rd_val = paddr[2] ? state_reg.acc[acc_idx][31:0]
                        : state_reg.acc[acc_idx][63:32];
                end else begin
                    hit = 1'b0;
                end
            end
        endcase
    end

    // Unmapped address answers with an error
    assign pslverr = access && !hit;

    // Operand selection
    always_comb begin
        mode = state_reg.instr[5:3];
        rn = state_reg.instr[2:0];
        acn = state_reg.instr[7:6];
        dbl = state_reg.stat[ST_DBL]; // RULE14
        fmask = dbl ? DBL_MASK : SGL_MASK;
        ac_v = state_reg.acc[acn] & fmask;
        // Mode 0 names an accumulator, others a fetched value
        if (mode == 3'h0) begin
            src_v = state_reg.acc[rn] & fmask; // RULE17
        end else begin
            src_v = state_reg.opnd & fmask; // RULE17
        end
        // Minus zero only counts when fetched from memory
        src_neg0 = mode != 3'h0 && src_v[63] && src_v[62:55] == 8'h00;
    end

    // Order operands by magnitude
    always_comb begin
        a_z = ac_v[62:55] == 8'h00; // RULE1
        b_z = src_v[62:55] == 8'h00; // RULE1
        swap = src_v[62:0] > ac_v[62:0];
        if (swap) begin
            big_f = {1'b1, src_v[54:0], 2'b00}; // RULE4 RULE5
            sm_f = {1'b1, ac_v[54:0], 2'b00};
            big_e = src_v[62:55];
            sm_e = ac_v[62:55];
            big_s = src_v[63];
            sm_s = ac_v[63];
        end else begin
            big_f = {1'b1, ac_v[54:0], 2'b00};
            sm_f = {1'b1, src_v[54:0], 2'b00};
            big_e = ac_v[62:55];
            sm_e = src_v[62:55];
            big_s = ac_v[63];
            sm_s = src_v[63];
        end
    end

    fra_align #(
        .W(58)
    ) u_align (
        .frac_in(sm_f),
        .shift(big_e - sm_e),
        .frac_out(al_f)
    );

    // Add or subtract, then normalise
    always_comb begin
        if (big_s == sm_s) begin
            sum = {1'b0, big_f} + {1'b0, al_f};
        end else begin
            sum = {1'b0, big_f} - {1'b0, al_f};
        end
        lz = lzc(sum[57:0]);
        if (sum[58]) begin
            nf = sum[58:1];
            ne = {3'b000, big_e} + 11'h001;
        end else begin
            nf = sum[57:0] << lz;
            ne = {3'b000, big_e} - {5'b00000, lz};
        end
    end

    fra_round u_round (
        .frac_in(nf),
        .exp_in(ne),
        .dbl(dbl),
        .chop(state_reg.stat[ST_CHOP]),
        .frac_out(rf),
        .exp_out(re)
    );

    // Range check and packing of the sum
    always_comb begin
        add_zero = sum == 59'h0;
        add_ovf = !re[10] && re > EXP_MAX; // RULE8
        add_unf = re[10] || re == 11'h000; // RULE8
        // Low eight exponent bits give the 400 octal wrap
        add_val = {big_s, re[7:0], rf[54:0]} & fmask; // RULE10 RULE11 RULE12
        if (a_z && b_z) begin
            add_val = 64'h0000_0000_0000_0000; // RULE2
            add_zero = 1'b1;
            add_ovf = 1'b0;
            add_unf = 1'b0;
        end else if (a_z || b_z) begin
            add_val = a_z ? src_v : ac_v; // RULE2
            add_zero = 1'b0;
            add_ovf = 1'b0;
            add_unf = 1'b0;
        end else if (add_zero) begin
            add_val = 64'h0000_0000_0000_0000;
            add_ovf = 1'b0;
            add_unf = 1'b0;
        end
    end

    // Register writes and instruction execution
    always_comb begin
        state_next = state_reg;
        state_next.trap = 1'b0;
        // Read data captured in the setup phase
        if (setup && !pwrite) begin
            state_next.rdata = rd_val;
        end
        // Writes take effect at the access edge
        if (access && pwrite) begin
            case (paddr)
                OFF_STAT: state_next.stat = pwdata[15:0] & ST_WMASK;
                OFF_INSTR: begin
                    state_next.instr = pwdata[15:0];
                    state_next.st = FRA_EXEC;
                end
                OFF_OPHI: state_next.opnd[63:32] = pwdata;
                OFF_OPLO: state_next.opnd[31:0] = pwdata;
                default: begin
                    if (paddr >= OFF_ACC && paddr < OFF_ACC_END && paddr[1:0] == 2'b00) begin
                        if (paddr[2]) begin
                            state_next.acc[acc_idx][31:0] = pwdata;
                        end else begin
                            state_next.acc[acc_idx][63:32] = pwdata;
                        end
                    end
                end
            endcase
        end
        case (state_reg.st)
            FRA_IDLE: begin
                // Waiting for an instruction word
            end
            FRA_EXEC: begin
                state_next.st = FRA_IDLE;
                state_next.trapped = 1'b0;
                if (state_reg.instr[15:12] != MAJ_FP
                    || (mode == 3'h0 && rn > ACC_LAST)) begin // RULE16
                    // Not ours or bad accumulator
                    state_next.ecode = EC_OPC; // RULE22
                    state_next.trap = 1'b1;
                end else if (state_reg.instr[11:6] == FOC1_ABS) begin // RULE16
                    if (src_neg0 && state_reg.stat[ST_UVIE]) begin
                        // Trap before anything is written
                        state_next.ecode = EC_UNDEF; // RULE19 RULE22
                        state_next.trap = 1'b1;
                    end else begin
                        if (mode == 3'h0) begin
                            state_next.acc[rn] = b_z ? 64'h0 : {1'b0, src_v[62:0]}; // RULE18
                        end else begin
                            state_next.res = b_z ? 64'h0 : {1'b0, src_v[62:0]}; // RULE18
                        end
                        state_next.stat[ST_C] = 1'b0; // RULE18
                        state_next.stat[ST_V] = 1'b0; // RULE19
                        state_next.stat[ST_N] = 1'b0;
                        state_next.stat[ST_Z] = b_z;
                    end
                end else if (state_reg.instr[11:8] == FOC_ADD) begin // RULE16
                    if (src_neg0 && state_reg.stat[ST_UVIE]) begin
                        state_next.ecode = EC_UNDEF; // RULE1 RULE22
                        state_next.trap = 1'b1;
                    end else begin
                        state_next.stat[ST_C] = 1'b0;
                        state_next.stat[ST_V] = add_ovf; // RULE13
                        if ((add_ovf && !state_reg.stat[ST_OVIE])
                            || (add_unf && !state_reg.stat[ST_UFIE])) begin
                            // Masked range error leaves exact zero
                            state_next.acc[acn] = 64'h0; // RULE9 RULE20
                            state_next.stat[ST_Z] = 1'b1;
                            state_next.stat[ST_N] = 1'b0;
                        end else begin
                            state_next.acc[acn] = add_val; // RULE20
                            state_next.stat[ST_Z] = add_zero;
                            state_next.stat[ST_N] = add_val[63] && !add_zero;
                        end
                        if (add_ovf && state_reg.stat[ST_OVIE]) begin
                            state_next.ecode = EC_OVF; // RULE13 RULE23
                            state_next.trap = 1'b1;
                        end else if (add_unf && state_reg.stat[ST_UFIE]) begin
                            state_next.ecode = EC_UNF; // RULE23
                            state_next.trap = 1'b1;
                        end
                    end
                end else if (state_reg.instr[11:8] == FOC_DIV && b_z) begin
                    // Zero divisor: abort, accumulator kept
                    state_next.ecode = EC_DIVZ; // RULE3
                    state_next.trap = 1'b1;
                end else if (state_reg.instr[11:8] == FOC_DIV && a_z) begin
                    state_next.acc[acn] = 64'h0; // RULE2
                    state_next.stat[ST_Z] = 1'b1;
                    state_next.stat[ST_N] = 1'b0;
                    state_next.stat[ST_V] = 1'b0;
                    state_next.stat[ST_C] = 1'b0;
                end else begin
                    // Other floating opcodes are not handled here
                    state_next.ecode = EC_OPC;
                    state_next.trap = 1'b1;
                end
                // Error flag is sticky, set wins over clear
                if (state_next.trap) begin
                    state_next.stat[ST_ERR] = 1'b1;
                    state_next.trapped = 1'b1;
                end
            end
            default: state_next.st = FRA_IDLE;
        endcase
    end

    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= '{st: FRA_IDLE, stat: ST_RESET, ecode: EC_NONE,
                instr: 16'h0000, opnd: 64'h0, res: 64'h0, acc: '0,
                rdata: 32'h0000_0000, trap: 1'b0, trapped: 1'b0};
        end else begin
            state_reg <= state_next;
        end
    end
endmodule
`default_nettype wire

// ---- verilog/fra_pkg.sv ----
// Shared constants and types for the floating round/absolute/add unit
package fra_pkg;
    // Register byte offsets
    localparam logic [7:0] OFF_STAT = 8'h00;
    localparam logic [7:0] OFF_ECODE = 8'h04;
    localparam logic [7:0] OFF_INSTR = 8'h08;
    localparam logic [7:0] OFF_OPHI = 8'h0C;
    localparam logic [7:0] OFF_OPLO = 8'h10;
    localparam logic [7:0] OFF_RSHI = 8'h14;
    localparam logic [7:0] OFF_RSLO = 8'h18;
    localparam logic [7:0] OFF_EXST = 8'h1C;
    localparam logic [7:0] OFF_ACC = 8'h20;
    localparam logic [7:0] OFF_ACC_END = 8'h50;
    // Status word bit positions
    localparam int ST_ERR = 15;
    localparam int ST_UVIE = 11;
    localparam int ST_UFIE = 10;
    localparam int ST_OVIE = 9;
    localparam int ST_DBL = 7;
    localparam int ST_LONG = 6;
    localparam int ST_CHOP = 5;
    localparam int ST_N = 3;
    localparam int ST_Z = 2;
    localparam int ST_V = 1;
    localparam int ST_C = 0;
    localparam logic [15:0] ST_WMASK = 16'h8EEF;
    localparam logic [15:0] ST_RESET = 16'h0000;
    // Instruction fields
    localparam logic [3:0] MAJ_FP = 4'hF;
    localparam logic [3:0] FOC_ADD = 4'h4;
    localparam logic [3:0] FOC_DIV = 4'h9;
    localparam logic [5:0] FOC1_ABS = 6'h06;
    localparam logic [2:0] ACC_LAST = 3'h5;
    // Exception codes
    localparam logic [3:0] EC_NONE = 4'h0;
    localparam logic [3:0] EC_OPC = 4'h2;
    localparam logic [3:0] EC_DIVZ = 4'h4;
    localparam logic [3:0] EC_OVF = 4'h8;
    localparam logic [3:0] EC_UNF = 4'hA;
    localparam logic [3:0] EC_UNDEF = 4'hC;
    // Number format
    localparam int FRAC_D = 56;
    localparam int FRAC_S = 24;
    localparam int GUARD = 2;
    localparam logic [10:0] EXP_MAX = 11'h0FF;
    localparam logic [63:0] SGL_MASK = 64'hFFFF_FFFF_0000_0000;
    localparam logic [63:0] DBL_MASK = 64'hFFFF_FFFF_FFFF_FFFF;
    // Execution states
    typedef enum logic [0:0] {FRA_IDLE, FRA_EXEC} fra_state_t;
endpackage

// ---- verilog/fra_align.sv ----
// Right shifter that aligns the smaller fraction to the larger exponent
`timescale 1ns/1ns
`default_nettype none
module fra_align #(
    parameter int W = 58
) (
    input wire logic [W-1:0] frac_in,
    input wire logic [7:0] shift,
    output logic [W-1:0] frac_out
);
    // Bits beyond the two guard bits are dropped
    always_comb begin
        if (int'(shift) >= W) begin
            frac_out = '0;
        end else begin
            frac_out = frac_in >> shift;
        end
    end
endmodule
`default_nettype wire

// ---- verilog/fra_round.sv ----
// Chop or round of a normalised fraction to single or double width
`timescale 1ns/1ns
`default_nettype none
module fra_round
    import fra_pkg::*;
(
    input wire logic [57:0] frac_in,
    input wire logic [10:0] exp_in,
    input wire logic dbl,
    input wire logic chop,
    output logic [55:0] frac_out,
    output logic [10:0] exp_out
);
    logic [55:0] kept;     // Chopped fraction
    logic rbit;            // First discarded bit
    logic [55:0] inc;      // One unit in the last kept place
    logic [56:0] sum;      // Rounded with carry
    // Keep 24 or 56 bits, then add one LSB when rounding bit set and chop is off
    always_comb begin
        if (dbl) begin
            kept = frac_in[57:GUARD];
            rbit = frac_in[GUARD-1];
            inc = 56'h00_0000_0000_0001;
        end else begin
            kept = {frac_in[57:57-FRAC_S+1], 32'h0000_0000};
            rbit = frac_in[57-FRAC_S];
            inc = 56'h00_0001_0000_0000;
        end
        if (!chop && rbit) begin
            sum = {1'b0, kept} + {1'b0, inc}; // RULE7 RULE21
        end else begin
            sum = {1'b0, kept}; // RULE6
        end
        // Carry out of the top bit renormalises
        if (sum[56]) begin
            frac_out = sum[56:1]; // RULE24
            exp_out = exp_in + 11'h001;
        end else begin
            frac_out = sum[55:0];
            exp_out = exp_in;
        end
    end
endmodule
`default_nettype wire

// ---- sim/fra_core_model.sv ----
// Core-side model: APB master, operand fetch and trap counter
`timescale 1ns/1ns
`default_nettype none
module fra_core_model (
    input wire logic pclk,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [7:0] paddr,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic fp_trap
);
    import fra_pkg::*;
    int trap_cnt = 0; // Trap pulses taken by the core
    // Idle bus from time zero
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
    end
    // One transfer, held until pready is sampled high
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] r, output logic e);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        r = prdata;
        e = pslverr;
        // Released lines no longer show the old value
        psel <= 1'b0;
        penable <= 1'b0;
        paddr <= ~a;
        pwdata <= ~d;
    endtask
    // Register write
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        xfer(1'b1, a, d, r, e);
    endtask
    // Register read with error response
    task automatic rd(input logic [7:0] a, output logic [31:0] r, output logic e);
        xfer(1'b0, a, 32'h0000_0000, r, e);
    endtask
    // Operand fetch for memory modes, then instruction
    task automatic issue(input logic [15:0] ins, input logic [31:0] hi, lo);
        if (ins[5:3] != 3'h0) begin
            wr(OFF_OPHI, hi);
            wr(OFF_OPLO, lo);
        end
        wr(OFF_INSTR, {16'h0000, ins});
    endtask
    // Counts each trap pulse once
    always @(posedge pclk) begin
        if (fp_trap === 1'b1) begin
            trap_cnt <= trap_cnt + 1;
        end
    end
endmodule
`default_nettype wire

// ---- sim/fra_unit_props.sv ----
// Port-level assertions for the floating absolute/add unit
`timescale 1ns/1ns
`default_nettype none
module fra_unit_props (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic fp_trap,
    input wire logic float_double_sel,
    input wire logic long_integer_sel
);
    import fra_pkg::*;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Access-phase decodes
    wire logic acc_w = psel && penable && pwrite;
    wire logic st_w = acc_w && paddr == OFF_STAT;
    wire logic in_w = acc_w && paddr == OFF_INSTR;
    property p_trap_pulse;
        fp_trap |=> !fp_trap;
    endproperty
    a_trap_pulse: assert property (p_trap_pulse) else $error("trap too long");
    property p_bad_major;
        in_w && pwdata[15:12] != MAJ_FP |-> ##[1:2] fp_trap;
    endproperty
    a_bad_major: assert property (p_bad_major) else $error("bad major not trapped");
    property p_ac_high;
        in_w && pwdata[15:8] == 8'hF4 && pwdata[5:3] == 3'h0 && pwdata[2:1] == 2'h3
            |-> ##[1:2] fp_trap;
    endproperty
    a_ac_high: assert property (p_ac_high) else $error("mode 0 AC6/7 not trapped");
    property p_dbl;
        st_w |=> float_double_sel == $past(pwdata[ST_DBL]);
    endproperty
    a_dbl: assert property (p_dbl) else $error("double select stale");
    property p_long;
        st_w |=> long_integer_sel == $past(pwdata[ST_LONG]);
    endproperty
    a_long: assert property (p_long) else $error("long select stale");
    property p_sel_hold;
        !st_w |=> $stable(float_double_sel) && $stable(long_integer_sel);
    endproperty
    a_sel_hold: assert property (p_sel_hold) else $error("mode select moved");
    property p_ecode;
        psel && penable && !pwrite && paddr == OFF_ECODE |-> !prdata[0] && prdata <= 32'd12;
    endproperty
    a_ecode: assert property (p_ecode) else $error("bad exception code");
    property p_trap_cause;
        fp_trap |-> $past(in_w, 1) || $past(in_w, 2);
    endproperty
    a_trap_cause: assert property (p_trap_cause) else $error("trap without instruction");
    property p_unmapped;
        psel && penable && (paddr[1:0] != 2'h0 || paddr >= OFF_ACC_END) |-> pslverr && pready;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped not refused");
    c_trap: cover property (in_w ##[1:2] fp_trap);
    c_stat: cover property (st_w && pwdata[ST_DBL]);
    c_err: cover property (pslverr);
endmodule
bind fra_unit fra_unit_props fra_unit_props_i (.*);
`default_nettype wire

// ---- sim/fra_unit_tb.sv ----
// Self-checking bench for the floating absolute/add unit
`timescale 1ns/1ns
`default_nettype none
module fra_unit_tb;
    import fra_pkg::*;
    localparam logic [31:0] Z32 = 32'h0000_0000;
    localparam logic [31:0] ONE = 32'h4080_0000; // +1.0 single
    localparam logic [31:0] TWO = 32'h4100_0000; // +2.0 single
    localparam logic [31:0] TINY = 32'h3480_0000; // 2**-24, lands on rounding bit
    localparam logic [31:0] BIG = 32'h7FC0_0000; // Top exponent
    localparam logic [15:0] ADD = 16'hF408; // Sum into AC0, mode 1
    localparam logic [15:0] ABS1 = 16'hF188; // Absolute, mode 1
    localparam logic [15:0] DIV = 16'hF908; // Divide AC0, mode 1
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel, penable, pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    logic pready, pslverr, fp_trap, float_double_sel, long_integer_sel;
    int n_mismatch = 0;
    int num_checks = 0;
    int cycles = 0;
    // 25 MHz clock
    always #20 pclk = ~pclk;
    fra_unit fra_unit_i (.*);
    fra_core_model fra_core_model_i (.pclk(pclk), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .fp_trap(fp_trap));
    // Counts and ends the run
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // Compare and report
    task automatic check(input string what, input logic [31:0] seen, exp);
        num_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // Hang guard
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 6000) begin
            n_mismatch++;
            print_verdict();
        end
    end
    // Load mode and AC0, execute, then check result, flags, code and trap count
    task automatic run(input logic [15:0] st, input logic [31:0] ahi, ohi, olo,
                       input logic [15:0] ins, input logic [31:0] ehi, elo,
                       input logic [3:0] ec, ef);
        logic [31:0] r;
        logic e;
        logic [15:0] m;
        logic [7:0] ra;
        int t0;
        ra = (ins[11:6] == FOC1_ABS && ins[5:3] != 3'h0) ? OFF_RSHI : OFF_ACC;
        m = (ec != 4'h0) ? (16'h8000 | ef) : 16'h800F;
        fra_core_model_i.wr(OFF_STAT, {16'h0000, st});
        fra_core_model_i.wr(OFF_ACC, ahi);
        fra_core_model_i.wr(OFF_ACC + 8'h04, Z32);
        check("double select", {31'h0, float_double_sel}, {31'h0, st[ST_DBL]});
        t0 = fra_core_model_i.trap_cnt;
        fra_core_model_i.issue(ins, ohi, olo);
        fra_core_model_i.rd(ra, r, e);
        check("result hi", r, ehi);
        fra_core_model_i.rd(ra + 8'h04, r, e);
        check("result lo", r, elo);
        fra_core_model_i.rd(OFF_STAT, r, e);
        check("status flags", {16'h0000, r[15:0] & m}, {16'h0000, ec != 4'h0, 11'h000, ef});
        check("trap count", 32'(fra_core_model_i.trap_cnt - t0), {31'h0, ec != 4'h0});
        fra_core_model_i.rd(OFF_EXST, r, e);
        check("trapped bit", r, {30'h0, ec != 4'h0, 1'b0});
        if (ec != 4'h0) begin
            fra_core_model_i.rd(OFF_ECODE, r, e);
            check("exception code", r, {28'h0, ec});
        end
    endtask
    // Main sequence
    initial begin
        logic [31:0] r;
        logic e;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        fra_core_model_i.rd(OFF_STAT, r, e);
        check("status reset", r, Z32);
        fra_core_model_i.rd(OFF_ACC, r, e);
        check("acc reset", r, Z32);
        fra_core_model_i.wr(OFF_STAT, 32'hFFFF_FFFF);
        fra_core_model_i.rd(OFF_STAT, r, e);
        check("status mask", r, 32'h0000_8EEF);
        check("long select", {31'h0, long_integer_sel}, 32'h0000_0001);
        fra_core_model_i.wr(OFF_ECODE, 32'h0000_000F);
        fra_core_model_i.rd(OFF_ECODE, r, e);
        check("ecode read-only", r, Z32);
        fra_core_model_i.rd(OFF_ACC_END, r, e);
        check("unmapped err", {31'h0, e}, 32'h0000_0001);
        check("unmapped data", r, Z32);
        fra_core_model_i.rd(8'h02, r, e);
        check("unaligned err", {31'h0, e}, 32'h0000_0001);
        fra_core_model_i.wr(OFF_STAT, Z32);
        @(posedge pclk);
        check("long select off", {31'h0, long_integer_sel}, Z32);
        run(16'h0000, ONE, ONE, 32'h0000_0001, ADD, TWO, Z32, 4'h0, 4'h0);
        run(16'h0000, ONE, 32'h1234_5678, Z32, 16'hF400, TWO, Z32, 4'h0, 4'h0);
        run(16'h0000, ONE, 32'h0000_1234, Z32, ADD, ONE, Z32, 4'h0, 4'h0);
        run(16'h0000, ONE, TINY, Z32, ADD, 32'h4080_0001, Z32, 4'h0, 4'h0);
        run(16'h0020, ONE, TINY, Z32, ADD, ONE, Z32, 4'h0, 4'h0);
        run(16'h0000, 32'h40FF_FFFF, TINY, Z32, ADD, TWO, Z32, 4'h0, 4'h0);
        run(16'h0000, BIG, BIG, Z32, ADD, Z32, Z32, 4'h0, 4'h6);
        run(16'h0200, BIG, BIG, Z32, ADD, 32'h0040_0000, Z32, 4'h8, 4'h2);
        run(16'h0000, 32'h00A0_0000, 32'h8080_0000, Z32, ADD, Z32, Z32, 4'h0, 4'h4);
        run(16'h0400, 32'h00A0_0000, 32'h8080_0000, Z32, ADD, 32'h7F80_0000, Z32, 4'hA,
            4'h0);
        run(16'h0000, Z32, 32'hC080_0000, Z32, ABS1, ONE, Z32, 4'h0, 4'h0);
        run(16'h0800, Z32, 32'h8000_0000, Z32, ABS1, ONE, Z32, 4'hC, 4'h0);
        run(16'h0000, Z32, 32'h0000_1234, Z32, ABS1, Z32, Z32, 4'h0, 4'h4);
        run(16'h0000, ONE, Z32, Z32, DIV, ONE, Z32, 4'h4, 4'h0);
        run(16'h0000, 32'h0000_1234, ONE, Z32, DIV, Z32, Z32, 4'h0, 4'h4);
        run(16'h0080, ONE, ONE, 32'h0000_0001, ADD, TWO, 32'h0000_0001, 4'h0, 4'h0);
        run(16'h00A0, ONE, ONE, 32'h0000_0001, ADD, TWO, Z32, 4'h0, 4'h0);
        run(16'h0000, ONE, ONE, Z32, 16'h7408, ONE, Z32, 4'h2, 4'h0);
        run(16'h0000, ONE, ONE, Z32, 16'hF406, ONE, Z32, 4'h2, 4'h0);
        print_verdict();
    end
endmodule
`default_nettype wire
